// ### hdl/pgen_color_pkg.sv
package pgen_color_pkg;

    // ***********************************************************************
    // Bus and register map (word index; byte address is four times it)
    // ***********************************************************************
    localparam int ADDR_W    = 10;
    localparam int DATA_W    = 32;
    localparam int BE_W      = 4;
    localparam int IDX_W     = 8;
    localparam int IDX_LSB   = 2;
    localparam int NUM_COLORS = 15;
    localparam int NUM_BARS   = 8;
    localparam int BAR_W      = 3;
    localparam int FIX_W      = 4;
    localparam int LEN_W      = 16;

    // Colour byte register index, byte 0 to byte 14
    localparam logic [IDX_W-1:0] COLOR_IDX [NUM_COLORS] = '{
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e};
    localparam logic [IDX_W-1:0] COLOR_BASE_IDX = 8'h10;
    localparam logic [IDX_W-1:0] CTRL_IDX       = 8'h20;
    localparam logic [IDX_W-1:0] LINE_LEN_IDX   = 8'h21;
    localparam logic [IDX_W-1:0] BAR_WIDTH_IDX  = 8'h22;
    localparam logic [IDX_W-1:0] STATUS_IDX     = 8'h23;

    // ***********************************************************************
    // Reset values
    // ***********************************************************************
    localparam logic [7:0] COLOR_RST [NUM_COLORS] = '{
        8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [1:0]       CTRL_RST      = 2'h0;
    localparam logic [LEN_W-1:0] LINE_LEN_RST  = 16'h0040;
    localparam logic [LEN_W-1:0] BAR_WIDTH_RST = 16'h0008;

    // ***********************************************************************
    // Field positions
    // ***********************************************************************
    localparam int CTRL_MODE_LSB  = 0;
    localparam int STAT_POS_LSB   = 0;
    localparam int STAT_BAR_LSB   = 16;
    localparam int STAT_FIX_LSB   = 20;
    localparam logic [FIX_W-1:0] FIX_LAST  = 4'he;
    localparam logic [BAR_W-1:0] BAR_LAST  = 3'h7;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_BAR,
        MODE_FIXED
    } pgen_mode_e;

endpackage

// ### hdl/pattern_color_gen.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
// Operation
// RQ1: Bar six carries colour byte six
// RQ2: Colour byte six is seventh fixed byte
// RQ3: Bar seven, last bar, carries byte seven
// RQ4: Colour byte seven is eighth fixed byte
// RQ5: Bytes eight to thirteen feed fixed only
// RQ6: Byte fourteen ends fifteen-byte fixed sequence
// RQ7: Bytes seven, six reset 0x80, 0x0F; 8-bit RW
// RQ8: Bytes eight to fourteen reset to zero
// RQ9: Bars zero to five carry bytes zero-five
// RQ10: Bytes zero-five are fixed bytes one-six
// RQ11: Fixed sequence repeats, restarts each line
module pattern_color_gen
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           resetn,
    // Avalon-MM slave
    input  wire logic [pgen_color_pkg::ADDR_W-1:0] address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [pgen_color_pkg::DATA_W-1:0] writedata,
    input  wire logic [pgen_color_pkg::BE_W-1:0]   byteenable,
    output logic      [pgen_color_pkg::DATA_W-1:0] readdata,
    output logic                                waitrequest,
    // Pattern byte stream
    output logic      [7:0]                     out_data,
    output logic                                out_sol,
    output logic                                out_eol,
    output logic                                out_valid,
    input  wire logic                           out_ready
);
    import pgen_color_pkg::*;

    // ***********************************************************************
    // Byte-lane merge
    // ***********************************************************************
    function automatic logic [DATA_W-1:0] merge_be(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < BE_W; b++)
        begin
            if (be[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    // ***********************************************************************
    // Bus slave
    // ***********************************************************************
    logic                 waitrequest_q;
    logic                 waitrequest_d;
    logic [DATA_W-1:0]    readdata_q;
    logic [7:0]           color_q [NUM_COLORS];
    logic [1:0]           ctrl_q;
    logic [LEN_W-1:0]     line_len_q;
    logic [LEN_W-1:0]     bar_width_q;
    logic [LEN_W-1:0]     pos_q;
    logic [LEN_W-1:0]     bar_cnt_q;
    logic [BAR_W-1:0]     bar_idx_q;
    logic [FIX_W-1:0]     fix_idx_q;

    wire [IDX_W-1:0]  word_idx  = address[IDX_LSB +: IDX_W];
    wire              wr_take   = write & ~waitrequest_q;
    wire              rd_start  = read & waitrequest_q;
    wire              is_color  = (word_idx >= COLOR_BASE_IDX) &&
                                  (word_idx < COLOR_BASE_IDX + IDX_W'(NUM_COLORS));
    wire [FIX_W-1:0]  color_sel = FIX_W'(word_idx - COLOR_BASE_IDX);
    wire              wr_ctrl   = wr_take && (word_idx == CTRL_IDX);
    wire              wr_len    = wr_take && (word_idx == LINE_LEN_IDX);
    wire              wr_barw   = wr_take && (word_idx == BAR_WIDTH_IDX);
    wire [DATA_W-1:0] merged_ctrl = merge_be(DATA_W'(ctrl_q), writedata, byteenable);
    wire [DATA_W-1:0] merged_len  = merge_be(DATA_W'(line_len_q), writedata, byteenable);
    wire [DATA_W-1:0] merged_barw = merge_be(DATA_W'(bar_width_q), writedata, byteenable);

    logic [DATA_W-1:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[STAT_POS_LSB +: LEN_W] = pos_q;
        status_word[STAT_BAR_LSB +: BAR_W] = bar_idx_q;
        status_word[STAT_FIX_LSB +: FIX_W] = fix_idx_q;
    end

    // Unmapped words read as zero, writes to them are dropped
    wire [DATA_W-1:0] rd_word =
        is_color                     ? DATA_W'(color_q[color_sel]) :
        (word_idx == CTRL_IDX)       ? DATA_W'(ctrl_q)             :
        (word_idx == LINE_LEN_IDX)   ? DATA_W'(line_len_q)         :
        (word_idx == BAR_WIDTH_IDX)  ? DATA_W'(bar_width_q)        :
        (word_idx == STATUS_IDX)     ? status_word                 : '0;

    // Every access answers one cycle after it appears
    assign waitrequest_d = ~((read | write) & waitrequest_q);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            waitrequest_q <= 1'b1;
            readdata_q    <= '0;
        end
        else
        begin
            waitrequest_q <= waitrequest_d;
            if (rd_start)
                readdata_q <= rd_word;
        end
    end

    // Colour bytes, one per generate slice
    generate
        for (genvar k = 0; k < NUM_COLORS; k++)
        begin : g_color
            wire hit = wr_take && (word_idx == COLOR_IDX[k]) && byteenable[0];
            always_ff @(posedge clk)
            begin
                if (!resetn)
                    color_q[k] <= COLOR_RST[k];       // [RQ7] [RQ8]
                else if (hit)
                    color_q[k] <= writedata[7:0];     // [RQ7]
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ctrl_q      <= CTRL_RST;
            line_len_q  <= LINE_LEN_RST;
            bar_width_q <= BAR_WIDTH_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= merged_ctrl[CTRL_MODE_LSB +: 2];
            if (wr_len)
                line_len_q <= merged_len[LEN_W-1:0];
            if (wr_barw)
                bar_width_q <= merged_barw[LEN_W-1:0];
        end
    end

    // ***********************************************************************
    // Pattern generator
    // ***********************************************************************
    pgen_mode_e mode;
    assign mode = pgen_mode_e'(ctrl_q);

    logic       gen_valid;
    logic [7:0] gen_data;
    always_comb
    begin
        gen_valid = 1'b0;
        gen_data  = '0;
        unique case (mode)
            MODE_OFF:
            begin
                gen_valid = 1'b0;
                gen_data  = '0;
            end
            MODE_BAR:
            begin
                gen_valid = 1'b1;
                gen_data  = color_q[FIX_W'(bar_idx_q)];  // [RQ1] [RQ3] [RQ5] [RQ9]
            end
            MODE_FIXED:
            begin
                gen_valid = 1'b1;
                gen_data  = color_q[fix_idx_q];  // [RQ2] [RQ4] [RQ5] [RQ6] [RQ10]
            end
            default:
            begin
                gen_valid = 1'b0;
                gen_data  = '0;
            end
        endcase
    end

    logic skid_valid_q;
    wire  gen_ready = ~skid_valid_q;
    wire  push      = gen_valid & gen_ready;
    wire  gen_sol   = (pos_q == '0);
    wire  gen_eol   = (pos_q == line_len_q - LEN_W'(1));
    wire  bar_end   = (bar_cnt_q == bar_width_q - LEN_W'(1));

    // A mode write restarts the line so the new pattern starts clean
    always_ff @(posedge clk)
    begin
        if (!resetn || wr_ctrl)
        begin
            pos_q     <= '0;
            bar_cnt_q <= '0;
            bar_idx_q <= '0;
            fix_idx_q <= '0;
        end
        else if (push)
        begin
            pos_q     <= gen_eol ? '0 : pos_q + LEN_W'(1);
            bar_cnt_q <= (gen_eol || bar_end) ? '0 : bar_cnt_q + LEN_W'(1);
            // Bars beyond the eighth wrap to bar zero
            bar_idx_q <= gen_eol ? '0 : (bar_end ? bar_idx_q + BAR_W'(1) : bar_idx_q);
            fix_idx_q <= (gen_eol || fix_idx_q == FIX_LAST) ? '0
                         : fix_idx_q + FIX_W'(1);                 // [RQ6] [RQ11]
        end
    end

    // ***********************************************************************
    // Two-entry output buffer
    // ***********************************************************************
    logic [9:0] skid_q;
    logic [9:0] out_q;
    logic       out_valid_q;
    wire  [9:0] gen_word = {gen_sol, gen_eol, gen_data};
    wire        out_free = ~out_valid_q | out_ready;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            out_valid_q  <= 1'b0;
            out_q        <= '0;
            skid_valid_q <= 1'b0;
            skid_q       <= '0;
        end
        else if (out_free)
        begin
            out_valid_q  <= skid_valid_q | push;
            out_q        <= skid_valid_q ? skid_q : (push ? gen_word : out_q);
            skid_valid_q <= 1'b0;
        end
        else if (push)
        begin
            skid_valid_q <= 1'b1;
            skid_q       <= gen_word;
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;
    assign out_valid   = out_valid_q;
    assign out_data    = out_q[7:0];
    assign out_eol     = out_q[8];
    assign out_sol     = out_q[9];

    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    property p_bar6;
        @(posedge clk) disable iff (!resetn)
        (push && mode == MODE_BAR && bar_idx_q == BAR_W'(6)) |-> gen_data == color_q[6];
    endproperty
    a_bar6: assert property (p_bar6) else $error("bar six byte wrong"); // [RQ1]

    property p_fix6;
        @(posedge clk) disable iff (!resetn)
        (push && mode == MODE_FIXED && fix_idx_q == FIX_W'(6)) |-> gen_data == color_q[6];
    endproperty
    a_fix6: assert property (p_fix6) else $error("fixed byte seven wrong"); // [RQ2]

    property p_bar7;
        @(posedge clk) disable iff (!resetn)
        (push && mode == MODE_BAR && bar_idx_q == BAR_LAST && !gen_eol && !bar_end && !wr_ctrl)
            |=> bar_idx_q == BAR_LAST && gen_data == color_q[7];
    endproperty
    a_bar7: assert property (p_bar7) else $error("bar seven byte wrong"); // [RQ3]

    property p_fix7;
        @(posedge clk) disable iff (!resetn)
        (push && mode == MODE_FIXED && fix_idx_q == FIX_W'(6) && !gen_eol && !wr_ctrl)
            |=> fix_idx_q == FIX_W'(7) && gen_data == color_q[7];
    endproperty
    a_fix7: assert property (p_fix7) else $error("fixed byte eight wrong"); // [RQ4]

    property p_bar_range;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_BAR && bar_idx_q < BAR_W'(6)) |-> gen_data == color_q[bar_idx_q];
    endproperty
    a_bar_range: assert property (p_bar_range) else $error("bar byte 0-5 wrong"); // [RQ9]

    property p_fix_wrap;
        @(posedge clk) disable iff (!resetn)
        (push && mode == MODE_FIXED && fix_idx_q == FIX_LAST && !wr_ctrl)
            |=> fix_idx_q == '0 && gen_data == color_q[0];
    endproperty
    a_fix_wrap: assert property (p_fix_wrap) else $error("fixed wrap wrong"); // [RQ6]

    property p_line_restart;
        @(posedge clk) disable iff (!resetn)
        (push && gen_eol) |=> pos_q == '0 && fix_idx_q == '0 && bar_idx_q == '0;
    endproperty
    a_line_restart: assert property (p_line_restart) else $error("line restart"); // [RQ11]

    property p_reset_vals;
        @(posedge clk) disable iff (!resetn)
        $past(!resetn) |-> color_q[6] == COLOR_RST[6] && color_q[7] == COLOR_RST[7]
                          && color_q[14] == COLOR_RST[14] && color_q[0] == COLOR_RST[0];
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values"); // [RQ7]

    property p_reset_zero;
        @(posedge clk) disable iff (!resetn)
        $past(!resetn) |-> color_q[8] == '0 && color_q[13] == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("upper bytes not zero"); // [RQ8]

    property p_color_write;
        @(posedge clk) disable iff (!resetn)
        (wr_take && is_color && byteenable[0])
            |=> color_q[$past(color_sel)] == $past(writedata[7:0]);
    endproperty
    a_color_write: assert property (p_color_write) else $error("colour write lost"); // [RQ7]

    property p_fix_low;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_FIXED && fix_idx_q < FIX_W'(6)) |-> gen_data == color_q[fix_idx_q];
    endproperty
    a_fix_low: assert property (p_fix_low) else $error("fixed bytes 1-6 wrong"); // [RQ10]

    property p_wait_answer;
        @(posedge clk) disable iff (!resetn)
        ((read || write) && waitrequest) |=> !waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");

    property p_hold_stall;
        @(posedge clk) disable iff (!resetn)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("word lost on stall");

    c_bar7:   cover property (@(posedge clk) push && mode == MODE_BAR && bar_idx_q == BAR_LAST);
    c_fixwrp: cover property (@(posedge clk) push && mode == MODE_FIXED && fix_idx_q == FIX_LAST);
    c_skid:   cover property (@(posedge clk) skid_valid_q && !out_ready);
    c_write:  cover property (@(posedge clk) wr_take && is_color);

endmodule // pattern_color_gen

// ### bench/pattern_generator_color_bytes_tb.sv
`timescale 1ns/10ps
module pattern_generator_color_bytes_tb;
    import pgen_color_pkg::*;

    // ***********************************************************************
    // Design hookup
    // ***********************************************************************
    localparam int LINE    = 20;
    localparam int TIMEOUT = 20000;

    logic                clk;
    logic                resetn;
    logic [ADDR_W-1:0]   address;
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   writedata;
    logic [BE_W-1:0]     byteenable;
    logic [DATA_W-1:0]   readdata;
    logic                waitrequest;
    logic [7:0]          out_data;
    logic                out_sol;
    logic                out_eol;
    logic                out_valid;
    logic                out_ready;
    logic [DATA_W-1:0]   rd;
    int                  n_errors;
    int                  compares;
    int                  cycles;

    pattern_color_gen i_pattern_color_gen (
        .clk         (clk),
        .resetn      (resetn),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .out_data    (out_data),
        .out_sol     (out_sol),
        .out_eol     (out_eol),
        .out_valid   (out_valid),
        .out_ready   (out_ready)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ***********************************************************************
    // Reporting
    // ***********************************************************************
    task automatic print_verdict();
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT)
        begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Distinct values, none equal to another, so a wrong index shows
    function automatic logic [7:0] col(input int i);
        return 8'h3c + 8'(i) * 8'h13;
    endfunction

    // ***********************************************************************
    // Avalon-MM master
    // ***********************************************************************
    task automatic wait_ack();
        int t;
        t = 0;
        do
        begin
            @(posedge clk);
            t = t + 1;
        end
        while (waitrequest !== 1'b0);
        // Answer comes exactly one cycle after the request appears
        check("bus wait edges", 32'h0000_0002, 32'(t));
    endtask

    task automatic bus_write(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
        address    <= {idx, 2'b00};
        writedata  <= d;
        byteenable <= be;
        write      <= 1'b1;
        wait_ack();
        write      <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_read(input logic [7:0] idx, output logic [31:0] d);
        address <= {idx, 2'b00};
        read    <= 1'b1;
        wait_ack();
        d = readdata;
        read    <= 1'b0;
        @(posedge clk);
    endtask

    // Stop the generator, drain the buffer, then nothing may come out
    task automatic stop_flush(input logic [31:0] m);
        bus_write(CTRL_IDX, m, 4'hf);
        out_ready <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        check("out_valid stopped", 32'h0000_0000, {31'h0, out_valid});
        @(posedge clk);
        out_ready <= 1'b0;
    endtask

    // ***********************************************************************
    // Stream receiver, stalls 3 of every 7 cycles so the buffer fills
    // ***********************************************************************
    task automatic collect(input int n, input logic bars, input int bw);
        int         k;
        int         t;
        int         pos;
        logic [7:0] e;
        k = 0;
        t = 0;
        while (k < n && t < 2000)
        begin
            @(negedge clk);
            if (out_valid === 1'b1 && out_ready === 1'b1)
            begin
                pos = k % LINE;
                e = bars ? col((pos / bw) % NUM_BARS) : col(pos % NUM_COLORS);
                check("out_data", {24'h0, e}, {24'h0, out_data});
                check("out_sol", 32'(pos == 0), {31'h0, out_sol});
                check("out_eol", 32'(pos == LINE - 1), {31'h0, out_eol});
                k = k + 1;
            end
            @(posedge clk);
            out_ready <= (t % 7) < 4;
            t = t + 1;
        end
        check("byte count", n, k);
    endtask

    // ***********************************************************************
    // Main sequence
    // ***********************************************************************
    initial
    begin
        logic [7:0] e;
        resetn     = 1'b0;
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = '0;
        byteenable = '0;
        out_ready  = 1'b0;
        n_errors   = 0;
        compares   = 0;
        cycles     = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < NUM_COLORS; i++)
        begin
            e = (i == 6) ? 8'h0f : (i == 7) ? 8'h80 : (i > 7) ? 8'h00 : COLOR_RST[i];
            bus_read(COLOR_IDX[i], rd);
            check("colour byte reset", {24'h0, e}, rd);
        end
        bus_read(LINE_LEN_IDX, rd);
        check("line length reset", {16'h0000, LINE_LEN_RST}, rd);
        bus_read(BAR_WIDTH_IDX, rd);
        check("bar width reset", {16'h0000, BAR_WIDTH_RST}, rd);
        // Upper lanes carry junk; only bits 7:0 may stick
        for (int i = 0; i < NUM_COLORS; i++)
            bus_write(COLOR_IDX[i], {24'h5a_5a5a, col(i)}, 4'hf);
        bus_write(COLOR_IDX[14], 32'h0000_0099, 4'he);
        for (int i = 0; i < NUM_COLORS; i++)
        begin
            bus_read(COLOR_IDX[i], rd);
            check("colour byte readback", {24'h0, col(i)}, rd);
        end
        bus_write(8'h30, 32'h0000_00ff, 4'hf);
        bus_read(8'h30, rd);
        check("unmapped word", 32'h0000_0000, rd);
        bus_write(LINE_LEN_IDX, 32'h0000_0014, 4'hf);
        bus_write(BAR_WIDTH_IDX, 32'h0000_0002, 4'hf);
        bus_read(LINE_LEN_IDX, rd);
        check("line length", 32'h0000_0014, rd);
        bus_read(BAR_WIDTH_IDX, rd);
        check("bar width", 32'h0000_0002, rd);
        // Fixed pattern: 20-byte lines show the wrap after 15 and the restart
        bus_write(CTRL_IDX, 32'h0000_0002, 4'hf);
        // Receiver stalled: both buffer entries full, generator parked at byte 2
        repeat (2) @(posedge clk);
        bus_read(STATUS_IDX, rd);
        check("status while stalled", 32'h0021_0002, rd);
        collect(2 * LINE, 1'b0, 2);
        // Code 3 must behave as off
        stop_flush(32'h0000_0003);
        // Bars two bytes wide; bytes 8 to 13 must never show up
        bus_write(CTRL_IDX, 32'h0000_0001, 4'hf);
        collect(2 * LINE, 1'b1, 2);
        stop_flush(32'h0000_0000);
        // Reset in mid-run must bring the defaults back over written values
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus_read(COLOR_IDX[6], rd);
        check("colour byte 6 after reset", 32'h0000_000f, rd);
        bus_read(COLOR_IDX[7], rd);
        check("colour byte 7 after reset", 32'h0000_0080, rd);
        bus_read(COLOR_IDX[14], rd);
        check("colour byte 14 after reset", 32'h0000_0000, rd);
        print_verdict();
    end

endmodule // pattern_generator_color_bytes_tb
